//--- verilog/sideband_defs.svh
// register offsets, field positions and timing counts for the sideband controller
`ifndef SIDEBAND_DEFS_SVH
`define SIDEBAND_DEFS_SVH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define REG_CONTROL 12'h000
`define REG_PINS 12'h004
`define REG_STATUS 12'h008
`define REG_MASK 12'h00c
`define REG_LOS_THRESH 12'h010
`define REG_LANE_LEVEL0 12'h020

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTL_TX_DISABLE 0
`define CTL_FORCE_LOW_POWER 1
`define PINS_SELECT 0
`define PINS_RESET 1
`define PINS_LOW_POWER 2
`define PINS_TX_OFF 3
`define PINS_INIT_PENDING 4
`define PINS_LOW_POWER_ACT 5
`define ST_RESET_DONE 0
`define ST_LOS_LANE0 1

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define CONTROL_RESET 32'h0000_0000
`define MASK_RESET 32'h0000_001f
`define LOS_THRESH_RESET 16'h0100
`define CLK_PERIOD_NS 20
`define RESET_MIN_PULSE_NS 10000
`define RESET_MIN_CYCLES ((`RESET_MIN_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWER_ON_INIT_MS 2000
`define POWER_ON_INIT_CYCLES ((`POWER_ON_INIT_MS * 1000000) / `CLK_PERIOD_NS)

`endif

//--- verilog/sideband_pkg.sv
// types shared by the sideband controller modules
package sideband_pkg;

  // ---------------------------------------------------------------
  // module life cycle
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    st_power_on,
    st_in_reset,
    st_ready
  } life_state_t;

endpackage

//--- verilog/lane_monitor_if.sv
// carrier between the lane monitor and the sideband top
`timescale 1ns/1ps
interface lane_monitor_if #(
  parameter int LANES = 4,
  parameter int LEVEL_W = 16
);
  logic [LEVEL_W-1:0] level [LANES];
  logic [LANES-1:0] lost;
  logic [LEVEL_W-1:0] threshold;

  modport mon (output level, output lost, input threshold);
  modport top (input level, input lost, output threshold);
endinterface

//--- verilog/lane_monitor.sv
// per-lane optical level capture and loss-of-signal compare
`timescale 1ns/1ps
module lane_monitor
  import sideband_pkg::*;
#(
  parameter int LANES = 4,
  parameter int LEVEL_W = 16
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [LANES*LEVEL_W-1:0] lane_level_i,
  lane_monitor_if.mon mon
);

  logic [LEVEL_W-1:0] level_q [LANES];
  logic [LEVEL_W-1:0] next_level [LANES];
  logic [LANES-1:0] lost_q;
  logic [LANES-1:0] next_lost;

  // ---------------------------------------------------------------
  // sampling
  // ---------------------------------------------------------------
  // levels come from the measuring adc on this clock, so no synchroniser
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      next_level[i] = lane_level_i[i*LEVEL_W +: LEVEL_W];
      next_lost[i] = level_q[i] < mon.threshold;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < LANES; i++)
        level_q[i] <= '0;
      lost_q <= '0;
    end
    else
    begin
      level_q <= next_level;
      lost_q <= next_lost;
    end
  end

  assign mon.level = level_q;
  assign mon.lost = lost_q;

  los_follows_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $past(rst_n_i) |-> lost_q[0] == $past(level_q[0] < mon.threshold))
    else $error("lane 0 loss flag does not follow compare");

endmodule

//--- verilog/pin_sync.sv
// two-flop synchroniser bank for the host control pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // ---------------------------------------------------------------
  // two stages, first stage read only by the second
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta <= RESET_VAL;
      sync_o <= RESET_VAL;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

//--- verilog/sideband_ctrl.sv
// sideband control and status of a four-lane optical module, with an ahb-lite register slave
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sideband_defs.svh"
module sideband_ctrl
  import sideband_pkg::*;
#(
  parameter int LANES = 4,
  parameter int LEVEL_W = 16,
  parameter int INIT_CYCLES = `POWER_ON_INIT_CYCLES,
  parameter int RESET_CYCLES = `RESET_MIN_CYCLES
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [11:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic module_select_n_i,
  input wire logic module_reset_n_i,
  input wire logic low_power_select_i,
  input wire logic transmit_disable_input_i,
  input wire logic [LANES*LEVEL_W-1:0] lane_level_i,
  output logic serial_access_en_o,
  output logic presence_n_o,
  output logic presence_n_oe_o,
  output logic interrupt_n_o,
  output logic interrupt_n_oe_o,
  output logic rx_signal_lost_alarm_o,
  output logic tx_output_off_o,
  output logic low_power_active_o,
  output logic irq_o
);

  localparam int STW = LANES + 1;
  localparam int CW = 32;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pins_sync;
  logic sel_n, mreset_n, lp_pin, txdis_pin;

  pin_sync #(.WIDTH(4), .RESET_VAL(4'h3)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({transmit_disable_input_i, low_power_select_i, module_reset_n_i, module_select_n_i}),
    .sync_o(pins_sync)
  );
  assign {txdis_pin, lp_pin, mreset_n, sel_n} = pins_sync;

  lane_monitor_if #(.LANES(LANES), .LEVEL_W(LEVEL_W)) lm ();

  lane_monitor #(.LANES(LANES), .LEVEL_W(LEVEL_W)) u_mon (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .lane_level_i(lane_level_i),
    .mon(lm)
  );

  // ---------------------------------------------------------------
  // life cycle: power-on wait, pin reset, ready
  // ---------------------------------------------------------------
  life_state_t state, next_state;
  logic [CW-1:0] cnt, next_cnt;
  logic done_pulse;
  logic soft_default;

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    done_pulse = 1'b0;
    soft_default = 1'b0;
    case (state)
      st_power_on:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt >= CW'(INIT_CYCLES - 1))
        begin
          next_state = st_ready;
          next_cnt = '0;
          done_pulse = 1'b1;
        end
      end
      st_ready:
      begin
        // count how long the reset pin stays low
        next_cnt = mreset_n ? '0 : cnt + 1'b1;
        if (!mreset_n && cnt >= CW'(RESET_CYCLES - 1))
        begin
          next_state = st_in_reset;
          soft_default = 1'b1;
        end
      end
      st_in_reset:
      begin
        next_cnt = '0;
        soft_default = 1'b1;
        if (mreset_n)
        begin
          next_state = st_ready;
          done_pulse = 1'b1;
        end
      end
      default:
      begin
        next_state = st_power_on;
        next_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= st_power_on;
      cnt <= '0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  wire init_pending = (state != st_ready);

  // ---------------------------------------------------------------
  // ahb-lite address phase capture
  // ---------------------------------------------------------------
  logic dp_wr, dp_rd, next_dp_wr, next_dp_rd;
  logic [11:0] dp_addr, next_dp_addr;
  wire ap_valid = hsel_i && htrans_i[1] && hready_i;

  always_comb
  begin
    next_dp_wr = ap_valid && hwrite_i;
    next_dp_rd = ap_valid && !hwrite_i;
    next_dp_addr = ap_valid ? haddr_i : dp_addr;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dp_wr <= 1'b0;
      dp_rd <= 1'b0;
      dp_addr <= '0;
    end
    else
    begin
      dp_wr <= next_dp_wr;
      dp_rd <= next_dp_rd;
      dp_addr <= next_dp_addr;
    end
  end

  // serial access is gated by module select; writes and reads vanish otherwise
  wire bus_ok = !sel_n && !init_pending;
  wire wr_en = dp_wr && bus_ok;
  wire rd_en = ap_valid && !hwrite_i && bus_ok;

  // ---------------------------------------------------------------
  // control, mask, threshold and sticky status
  // ---------------------------------------------------------------
  logic [1:0] control, next_control;
  logic [STW-1:0] mask, next_mask, status, next_status;
  logic [LEVEL_W-1:0] thresh, next_thresh;
  logic [LANES-1:0] lost_d, next_lost_d;
  logic [STW-1:0] events;

  always_comb
  begin
    // losses count only once ready: the level registers reset to zero and would
    // otherwise post a false loss on every lane straight after reset
    events = {lm.lost & ~lost_d & {LANES{!init_pending}}, done_pulse};
    next_lost_d = init_pending ? '0 : lm.lost;
    next_control = control;
    next_mask = mask;
    next_thresh = thresh;
    next_status = status;
    if (soft_default)
    begin
      next_control = 2'(`CONTROL_RESET);
      next_mask = STW'(`MASK_RESET);
      next_thresh = LEVEL_W'(`LOS_THRESH_RESET);
      // completion leaving reset must still latch, set wins over the clear
      next_status = STW'(done_pulse);
    end
    else
    begin
      if (wr_en && dp_addr == `REG_CONTROL)
        next_control = hwdata_i[1:0];
      if (wr_en && dp_addr == `REG_MASK)
        next_mask = hwdata_i[STW-1:0];
      if (wr_en && dp_addr == `REG_LOS_THRESH)
        next_thresh = hwdata_i[LEVEL_W-1:0];
      // read clears, a fresh event in the same cycle wins
      if (rd_en && haddr_i == `REG_STATUS)
        next_status = '0;
      next_status = next_status | events;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      control <= 2'(`CONTROL_RESET);
      mask <= STW'(`MASK_RESET);
      thresh <= LEVEL_W'(`LOS_THRESH_RESET);
      status <= '0;
      lost_d <= '0;
    end
    else
    begin
      control <= next_control;
      mask <= next_mask;
      thresh <= next_thresh;
      status <= next_status;
      lost_d <= next_lost_d;
    end
  end

  assign lm.threshold = thresh;

  // ---------------------------------------------------------------
  // read data, captured in the address phase so status clears once
  // ---------------------------------------------------------------
  logic [31:0] rdata, next_rdata;

  always_comb
  begin
    next_rdata = '0;
    if (rd_en)
    begin
      case (haddr_i)
        `REG_CONTROL: next_rdata = {30'h0, control};
        `REG_PINS: next_rdata = {26'h0, low_power_active_o, init_pending, tx_output_off_o,
                                 lp_pin, !mreset_n, !sel_n};
        `REG_STATUS: next_rdata = 32'(status);
        `REG_MASK: next_rdata = 32'(mask);
        `REG_LOS_THRESH: next_rdata = 32'(thresh);
        default:
        begin
          for (int i = 0; i < LANES; i++)
            if (haddr_i == 12'(`REG_LANE_LEVEL0 + 4 * i))
              next_rdata = 32'(lm.level[i]);
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata <= '0;
    else
      rdata <= next_rdata;
  end

  assign hrdata_o = rdata;
  assign hreadyout_o = 1'b1; // zero wait states
  assign hresp_o = 1'b0;

  // ---------------------------------------------------------------
  // pin outputs
  // ---------------------------------------------------------------
  wire irq_level = |(status & mask);
  assign irq_o = irq_level;
  // open drain: drive low while asserted, else release to host pull-up
  assign interrupt_n_o = 1'b0;
  assign interrupt_n_oe_o = irq_level;
  assign presence_n_o = 1'b0;
  assign presence_n_oe_o = 1'b1;
  assign rx_signal_lost_alarm_o = |lm.lost;
  assign tx_output_off_o = txdis_pin || control[`CTL_TX_DISABLE];
  assign low_power_active_o = lp_pin || control[`CTL_FORCE_LOW_POWER];
  assign serial_access_en_o = !sel_n;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  no_write_unsel_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (dp_wr && sel_n && state == st_ready && dp_addr == `REG_CONTROL) |=> $stable(control))
    else $error("control written while module not selected");

  reset_default_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == st_in_reset) |=> (control == 2'h0 && status[LANES:1] == '0))
    else $error("settings not at default during reset");

  done_sets_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    done_pulse |=> status[`ST_RESET_DONE] && !init_pending)
    else $error("reset completion not latched");

  power_up_done_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == st_power_on && next_state == st_ready) |-> done_pulse)
    else $error("power-up completion not posted");

  irq_follows_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    interrupt_n_oe_o == |(status & mask))
    else $error("interrupt pin disagrees with status and mask");

  los_any_lane_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_signal_lost_alarm_o == (lm.lost != '0))
    else $error("loss alarm disagrees with lanes");

  tx_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (txdis_pin || control[0]) |-> tx_output_off_o)
    else $error("transmitter left on while disabled");

  low_power_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lp_pin |-> low_power_active_o)
    else $error("low power select ignored");

  presence_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    presence_n_oe_o && !presence_n_o)
    else $error("presence not driven low");

  irq_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (irq_level && !(rd_en && haddr_i == `REG_STATUS) && !soft_default && !(wr_en && dp_addr == `REG_MASK))
    |=> irq_level)
    else $error("interrupt dropped before status read");

  init_time_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == st_power_on) |-> cnt < CW'(INIT_CYCLES))
    else $error("power-on wait overran");

  cov_done_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) done_pulse);
  cov_pin_reset_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) state == st_in_reset);
  cov_los_irq_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) status[1] && irq_level);
  cov_clear_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) $fell(irq_level));

endmodule

//--- tb/host_model.sv
// host board controller model: control pins, pull-ups and reset sequencing
`timescale 1ns/1ps
module host_model (
  input wire logic clk_i,
  input wire logic presence_n_oe_i,
  input wire logic interrupt_n_oe_i,
  output logic module_select_n_o,
  output logic module_reset_n_o,
  output logic low_power_select_o,
  output logic transmit_disable_input_o,
  output logic presence_line_o,
  output logic interrupt_line_o
);
  // ---------------------------------------------------------------
  // open-drain lines
  // ---------------------------------------------------------------
  // host pull-ups: a released line reads high, never the last level
  assign presence_line_o = presence_n_oe_i ? 1'b0 : 1'b1;
  assign interrupt_line_o = interrupt_n_oe_i ? 1'b0 : 1'b1;

  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // this module gets a select line of its own, never shared
  initial
  begin
    module_select_n_o = 1'b0;
    module_reset_n_o = 1'b1;
    low_power_select_o = 1'b0;
    transmit_disable_input_o = 1'b0;
  end

  // pins change just after an edge, like any synchronous host
  task automatic drive(input logic sel_n, input logic lp, input logic txd);
    @(posedge clk_i);
    module_select_n_o <= sel_n;
    low_power_select_o <= lp;
    transmit_disable_input_o <= txd;
  endtask

  // status is meaningless until completion shows on the interrupt line
  task automatic reset_pulse(input int len, input bit wait_done, output int cnt);
    @(posedge clk_i);
    module_reset_n_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    module_reset_n_o <= 1'b1;
    cnt = 0;
    while (wait_done && interrupt_line_o !== 1'b0 && cnt < 200)
    begin
      @(posedge clk_i);
      cnt++;
    end
  endtask
endmodule

//--- tb/optical_module_sideband_control_bench.sv
// self-checking bench for the sideband controller with an ahb-lite master
`timescale 1ns/1ps
`include "sideband_defs.svh"
module optical_module_sideband_control_bench
  import sideband_pkg::*;
;
  localparam int INIT = 50;
  localparam int RC = 4;
  logic clk_i = 1'b0, rst_n_i = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_act = 1'b0;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'b00;
  logic [31:0] hwdata = 32'h0, hrdata_o, seed = 32'he2eb;
  logic hreadyout_o, hresp_o, sel_n, rst_pin_n, lp_pin, txd_pin, access_en, pres_oe, int_oe;
  logic pres_line, int_line, alarm, tx_off, lp_act, irq_o;
  logic [15:0] lvl [4] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff};
  logic [3:0] nl, prev;
  logic [31:0] expq [$];
  int n_errors = 0, checked = 0, cnt;

  always #10 clk_i = ~clk_i;

  sideband_ctrl #(.INIT_CYCLES(INIT), .RESET_CYCLES(RC)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .module_select_n_i(sel_n), .module_reset_n_i(rst_pin_n), .low_power_select_i(lp_pin),
    .transmit_disable_input_i(txd_pin), .lane_level_i({lvl[3], lvl[2], lvl[1], lvl[0]}),
    .serial_access_en_o(access_en), .presence_n_o(), .presence_n_oe_o(pres_oe),
    .interrupt_n_o(), .interrupt_n_oe_o(int_oe), .rx_signal_lost_alarm_o(alarm),
    .tx_output_off_o(tx_off), .low_power_active_o(lp_act), .irq_o(irq_o));

  host_model hm (
    .clk_i(clk_i), .presence_n_oe_i(pres_oe), .interrupt_n_oe_i(int_oe),
    .module_select_n_o(sel_n), .module_reset_n_o(rst_pin_n), .low_power_select_o(lp_pin),
    .transmit_disable_input_o(txd_pin), .presence_line_o(pres_line), .interrupt_line_o(int_line));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("errors %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // read data stands only in its data phase, so the watcher samples there
  always @(posedge clk_i)
  begin
    if (rd_act)
      chk(hrdata_o, expq.pop_front());
  end

  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  // no wait is open-ended: a stuck hready ends the run
  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (hreadyout_o !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      n_errors++;
      $display("BAD %0t: hready timeout", $time);
      summarize();
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_act <= !w;
    wait_ready();
    rd_act <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    expq.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // power-up: completion must come by itself, within ten cycles of the init time
    cnt = 0;
    while (irq_o !== 1'b1 && cnt < INIT + 20)
    begin
      @(posedge clk_i);
      cnt++;
    end
    chk(cnt <= INIT + 10, 1);
    chk(int_line, 1'b0);
    chk(pres_line, 1'b0);
    chk(hresp_o, 1'b0);
    rd(`REG_PINS, 32'h1);
    rd(`REG_STATUS, 32'h1);
    chk(irq_o, 1'b0);
    rd(`REG_STATUS, 32'h0);
    rd(`REG_MASK, 32'h1f);
    rd(`REG_LOS_THRESH, 32'h100);
    rd(`REG_CONTROL, 32'h0);
    rd(12'h0fc, 32'h0);
    // select gating: writes while deselected are dropped
    hm.drive(1'b1, 1'b0, 1'b0);
    repeat (5) @(posedge clk_i);
    chk(access_en, 1'b0);
    bus(1'b1, `REG_CONTROL, 32'h1);
    rd(`REG_CONTROL, 32'h0);
    hm.drive(1'b0, 1'b0, 1'b0);
    repeat (5) @(posedge clk_i);
    chk(access_en, 1'b1);
    rd(`REG_CONTROL, 32'h0);
    // all four combinations of the two pins together and the two control bits together, for disable and low power
    for (int i = 0; i < 4; i++)
    begin
      hm.drive(1'b0, i[0], i[0]);
      bus(1'b1, `REG_CONTROL, {30'h0, i[1], i[1]});
      repeat (5) @(posedge clk_i);
      chk(tx_off, |i[1:0]);
      chk(lp_act, |i[1:0]);
      rd(`REG_PINS, {26'h0, |i[1:0], 1'b0, |i[1:0], i[0], 2'b01});
    end
    hm.drive(1'b0, 1'b0, 1'b0);
    bus(1'b1, `REG_CONTROL, 32'h0);
    // random lane levels around the threshold; status latches new losses
    bus(1'b1, `REG_LOS_THRESH, 32'h8000);
    prev = 4'h0;
    for (int k = 0; k < 6; k++)
    begin
      @(posedge clk_i);
      for (int j = 0; j < 4; j++)
      begin
        seed = xs(seed);
        lvl[j] <= seed[15:0];
        nl[j] = seed[15:0] < 16'h8000;
      end
      repeat (6) @(posedge clk_i);
      chk(alarm, |nl);
      chk(irq_o, |(nl & ~prev));
      for (int j = 0; j < 4; j++)
        rd(`REG_LANE_LEVEL0 + 12'(4 * j), {16'h0, lvl[j]});
      rd(`REG_STATUS, {27'h0, nl & ~prev, 1'b0});
      rd(`REG_STATUS, 32'h0);
      chk(irq_o, 1'b0);
      prev = nl;
    end
    // a masked loss still latches but keeps the interrupt quiet
    @(posedge clk_i);
    lvl <= '{16'hffff, 16'hffff, 16'hffff, 16'hffff};
    repeat (6) @(posedge clk_i);
    rd(`REG_STATUS, 32'h0);
    bus(1'b1, `REG_MASK, 32'h1);
    lvl[0] <= 16'h0000;
    repeat (6) @(posedge clk_i);
    chk(alarm, 1'b1);
    chk(irq_o, 1'b0);
    rd(`REG_STATUS, 32'h2);
    lvl[0] <= 16'hffff;
    // pin reset: a short pulse is ignored, a long one restores defaults
    bus(1'b1, `REG_CONTROL, 32'h3);
    bus(1'b1, `REG_MASK, 32'h0);
    hm.reset_pulse(1, 1'b0, cnt);
    repeat (6) @(posedge clk_i);
    rd(`REG_CONTROL, 32'h3);
    hm.reset_pulse(RC + 4, 1'b1, cnt);
    chk(cnt < 200, 1);
    chk(irq_o, 1'b1);
    chk(tx_off, 1'b0);
    rd(`REG_PINS, 32'h1);
    rd(`REG_STATUS, 32'h1);
    rd(`REG_CONTROL, 32'h0);
    rd(`REG_MASK, 32'h1f);
    rd(`REG_LOS_THRESH, 32'h100);
    chk(irq_o, 1'b0);
    summarize();
  end
endmodule
